/* verilog/opc_top.sv */
// output loop control register set on a classic wishbone slave
`timescale 1ns/1ps
module opc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic loop_locked_i,
  output logic [7:0] pump_current_o,
  output logic [5:0] fb_main_count_o,
  output logic [1:0] fb_rem_count_o,
  output logic [7:0] fb_ratio_o,
  output logic lockdet_pd_o,
  output logic ref_doubler_o,
  output logic [1:0] phase_freq_detector_ab_o,
  output opc_pkg::opc_cp_mode_type cp_mode_o,
  output logic vco_midscale_o,
  output logic sync_hold_o,
  output logic sync_release_o,
  output logic cal_start_o,
  output logic cal_reset_o
);
  import opc_pkg::*;
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic [7:0] pump_r;
  logic [7:0] fb_r;
  logic [7:0] lc_r;
  logic [7:0] oc_r;
  logic sync_hold;
  logic sync_rel;
  logic cal_start;
  logic cal_reset;
  wire [7:0] idx = wb_adr_i[9:2];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire hit_pump = (idx == IDX_PUMP_CURRENT);
  wire hit_fb = (idx == IDX_FB_COUNTS);
  wire hit_lc = (idx == IDX_LOOP_CTRL);
  wire hit_oc = (idx == IDX_OSC_CTRL);
  wire hit_st = (idx == IDX_STATUS);
  wire mapped = (hit_pump | hit_fb | hit_lc | hit_oc | hit_st)
    & (wb_adr_i[11:10] == 2'h0) & (wb_adr_i[1:0] == 2'h0);
  wire wr_lane0 = req & mapped & wb_we_i & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire [7:0] lc_wd = wd & LC_WMASK;
  wire [7:0] oc_wd = wd & OC_WMASK;
  // select rising forces minimum width, whatever width is written
  wire ab_rise = wr_lane0 & hit_lc & ~lc_r[LC_AB_SEL] & lc_wd[LC_AB_SEL];
  wire [7:0] lc_nxt = ab_rise
    ? {lc_wd[7:LC_AB_MSB + 1], AB_MIN, lc_wd[LC_CP_MSB:0]} : lc_wd;
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pump_r <= RST_PUMP_CURRENT;
      fb_r <= RST_FB_COUNTS;
      lc_r <= RST_LOOP_CTRL;
      oc_r <= RST_OSC_CTRL;
    end else if (wr_lane0) begin
      if (hit_pump) begin
        pump_r <= wd;
      end
      if (hit_fb) begin
        fb_r <= wd;
      end
      if (hit_lc) begin
        lc_r <= lc_nxt;
      end
      if (hit_oc) begin
        oc_r <= oc_wd;
      end
    end
  end
  // ------------------------------------------------------------
  // read mux and bus answer
  // ------------------------------------------------------------
  wire [7:0] status = {5'h00, cal_start, sync_hold, loop_locked_i};
  wire [7:0] rd = hit_pump ? pump_r : hit_fb ? fb_r : hit_lc ? lc_r
    : hit_oc ? oc_r : hit_st ? status : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= {24'h00_0000, (req & mapped & ~wb_we_i) ? rd : 8'h00};
    end
  end
  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------
  // ratio is 4 x main + remainder
  wire [7:0] ratio = {fb_r[FB_MAIN_MSB:0], 2'h0}
    + {6'h00, fb_r[7:FB_REM_LSB]};
  // automatic high width while select is low
  wire [1:0] ab_eff = lc_r[LC_AB_SEL] ? lc_r[LC_AB_MSB:LC_AB_LSB]
    : AB_AUTO_HIGH;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pump_current_o <= RST_PUMP_CURRENT;
      fb_main_count_o <= 6'h00;
      fb_rem_count_o <= 2'h0;
      fb_ratio_o <= 8'h00;
      lockdet_pd_o <= 1'b0;
      ref_doubler_o <= 1'b0;
      phase_freq_detector_ab_o <= AB_AUTO_HIGH;
      cp_mode_o <= OPC_CP_NORMAL;
      vco_midscale_o <= 1'b0;
      sync_hold_o <= 1'b1;
      sync_release_o <= 1'b0;
      cal_start_o <= 1'b0;
      cal_reset_o <= 1'b1;
    end else begin
      pump_current_o <= pump_r;
      fb_main_count_o <= fb_r[FB_MAIN_MSB:0];
      fb_rem_count_o <= fb_r[7:FB_REM_LSB];
      fb_ratio_o <= ratio;
      lockdet_pd_o <= lc_r[LC_LOCKDET_PD];
      ref_doubler_o <= lc_r[LC_DOUBLER];
      phase_freq_detector_ab_o <= ab_eff;
      cp_mode_o <= opc_cp_mode_type'(lc_r[LC_CP_MSB:0]);
      vco_midscale_o <= oc_r[OC_MIDSCALE];
      sync_hold_o <= sync_hold;
      sync_release_o <= sync_rel;
      cal_start_o <= cal_start;
      cal_reset_o <= cal_reset;
    end
  end
  // ------------------------------------------------------------
  // sequencers
  // ------------------------------------------------------------
  // a powered-down detector cannot report lock to the sync sequencer; status bit 0 still reads loop_locked_i
  wire locked_eff = loop_locked_i & ~lc_r[LC_LOCKDET_PD];
  opc_sync_ctrl u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .locked_i(locked_eff),
    .override_i(oc_r[OC_SYNC_OVR]),
    .hold_o(sync_hold),
    .release_pulse_o(sync_rel)
  );
  // restart needs a fresh 0 then 1
  opc_cal_ctrl u_cal (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cal_bit_i(oc_r[OC_CAL]),
    .cal_start_o(cal_start),
    .cal_reset_o(cal_reset)
  );
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_RATIO: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 fb_ratio_o == 8'(4 * $past(fb_r[5:0]) + $past(fb_r[7:6])))
    else $error("feedback ratio wrong");
  AST_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
    !lc_r[LC_RSVD] && !oc_r[OC_RSVD])
    else $error("reserved bit set");
  AST_AB_AUTO: assert property (@(posedge clk_i) disable iff (rst_i)
    !lc_r[LC_AB_SEL] |=> phase_freq_detector_ab_o == AB_AUTO_HIGH)
    else $error("auto antibacklash not high");
  AST_AB_MIN: assert property (@(posedge clk_i) disable iff (rst_i)
    ab_rise |=> lc_r[LC_AB_MSB:LC_AB_LSB] == AB_MIN)
    else $error("width not minimum after select");
  AST_PD: assert property (@(posedge clk_i) disable iff (rst_i)
    lc_r[LC_LOCKDET_PD] |=> lockdet_pd_o)
    else $error("lock detector power-down missing");
  AST_CP: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 cp_mode_o == opc_cp_mode_type'($past(lc_r[1:0])))
    else $error("pump mode wrong");
  AST_MID: assert property (@(posedge clk_i) disable iff (rst_i)
    oc_r[OC_MIDSCALE] |=> vco_midscale_o)
    else $error("midscale not forced");
  AST_OVR: assert property (@(posedge clk_i) disable iff (rst_i)
    oc_r[OC_SYNC_OVR] |-> ##[1:3] !sync_hold_o)
    else $error("override did not release sync");
  COV_WRITE: cover property (@(posedge clk_i) wr_lane0 && hit_lc);
  COV_RELEASE: cover property (@(posedge clk_i) sync_release_o);
  COV_ERR: cover property (@(posedge clk_i) wb_err_o);
endmodule

/* verilog/opc_pkg.sv */
// package of offsets, fields and reset values for the output loop controls
package opc_pkg;
  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_PUMP_CURRENT = 8'hf0;
  localparam logic [7:0] IDX_FB_COUNTS = 8'hf1;
  localparam logic [7:0] IDX_LOOP_CTRL = 8'hf2;
  localparam logic [7:0] IDX_OSC_CTRL = 8'hf3;
  localparam logic [7:0] IDX_STATUS = 8'hf8;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int FB_REM_LSB = 6;
  localparam int FB_MAIN_MSB = 5;
  localparam int LC_LOCKDET_PD = 7;
  localparam int LC_RSVD = 6;
  localparam int LC_DOUBLER = 5;
  localparam int LC_AB_SEL = 4;
  localparam int LC_AB_MSB = 3;
  localparam int LC_AB_LSB = 2;
  localparam int LC_CP_MSB = 1;
  localparam int OC_SYNC_OVR = 4;
  localparam int OC_RSVD = 3;
  localparam int OC_MIDSCALE = 2;
  localparam int OC_CAL = 1;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] RST_PUMP_CURRENT = 8'h00;
  localparam logic [7:0] RST_FB_COUNTS = 8'h00;
  localparam logic [7:0] RST_LOOP_CTRL = 8'h03;
  localparam logic [7:0] RST_OSC_CTRL = 8'h00;
  localparam logic [1:0] AB_AUTO_HIGH = 2'h2;
  localparam logic [1:0] AB_MIN = 2'h0;
  localparam logic [7:0] LC_WMASK = 8'hbf;
  localparam logic [7:0] OC_WMASK = 8'h16;
  typedef enum {
    OPC_SYNC_HOLD,
    OPC_SYNC_RELEASED
  } opc_sync_type;
  typedef enum logic [1:0] {
    OPC_CP_TRISTATE,
    OPC_CP_PUMP_UP,
    OPC_CP_PUMP_DOWN,
    OPC_CP_NORMAL
  } opc_cp_mode_type;
endpackage

/* verilog/opc_sync_ctrl.sv */
// distribution sync hold and release sequencer
`timescale 1ns/1ps
module opc_sync_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic locked_i,
  input wire logic override_i,
  output logic hold_o,
  output logic release_pulse_o
);
  import opc_pkg::*;
  opc_sync_type state_r;
  opc_sync_type state_nxt;
  wire go = locked_i | override_i;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OPC_SYNC_HOLD: begin
        if (go) begin
          state_nxt = OPC_SYNC_RELEASED;
        end
      end
      OPC_SYNC_RELEASED: begin
        if (!go) begin
          state_nxt = OPC_SYNC_HOLD;
        end
      end
      default: state_nxt = OPC_SYNC_HOLD;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= OPC_SYNC_HOLD;
      hold_o <= 1'b1;
      release_pulse_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_o <= (state_nxt == OPC_SYNC_HOLD);
      release_pulse_o <= (state_r == OPC_SYNC_HOLD) && go;
    end
  end
  // all dividers leave sync together in one pulse
  AST_SYNC_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == OPC_SYNC_HOLD && go) |=> release_pulse_o && !hold_o)
    else $error("sync release did not follow lock");
  AST_SYNC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (!locked_i && !override_i) |=> hold_o)
    else $error("sync not held while unlocked");
endmodule

/* verilog/opc_cal_ctrl.sv */
// vco calibration start and reset logic
`timescale 1ns/1ps
module opc_cal_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cal_bit_i,
  output logic cal_start_o,
  output logic cal_reset_o
);
  logic prev_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
      cal_start_o <= 1'b0;
      cal_reset_o <= 1'b1;
    end else begin
      prev_r <= cal_bit_i;
      cal_start_o <= cal_bit_i & ~prev_r;
      cal_reset_o <= ~cal_bit_i;
    end
  end
  AST_CAL_START: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(cal_bit_i) |=> cal_start_o ##1 !cal_start_o)
    else $error("calibration start pulse wrong");
  AST_CAL_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    !cal_bit_i |=> cal_reset_o && !cal_start_o)
    else $error("calibration not reset while bit low");
  COV_CAL: cover property (@(posedge clk_i) disable iff (rst_i)
    cal_start_o);
endmodule

/* testbench/test_opc_top.sv */
// self-checking bench for the output loop control register set
`timescale 1ns/1ps
module test_opc_top;
  import opc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic loop_locked_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, lockdet_pd_o, ref_doubler_o, vco_midscale_o;
  logic sync_hold_o, sync_release_o, cal_start_o, cal_reset_o;
  logic [7:0] pump_current_o, fb_ratio_o;
  logic [5:0] fb_main_count_o;
  logic [1:0] fb_rem_count_o, phase_freq_detector_ab_o;
  opc_cp_mode_type cp_mode_o;
  int failures = 0;
  int tests_run = 0;
  logic [7:0] n_cal = 8'h00;
  logic [7:0] n_rel = 8'h00;
  logic [7:0] rd;
  logic er;
  opc_top opc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .loop_locked_i(loop_locked_i),
    .pump_current_o(pump_current_o), .fb_main_count_o(fb_main_count_o),
    .fb_rem_count_o(fb_rem_count_o), .fb_ratio_o(fb_ratio_o),
    .lockdet_pd_o(lockdet_pd_o), .ref_doubler_o(ref_doubler_o),
    .phase_freq_detector_ab_o(phase_freq_detector_ab_o),
    .cp_mode_o(cp_mode_o), .vco_midscale_o(vco_midscale_o),
    .sync_hold_o(sync_hold_o), .sync_release_o(sync_release_o),
    .cal_start_o(cal_start_o), .cal_reset_o(cal_reset_o));
  always #20 clk_i = ~clk_i;
  // pulses last one cycle, so they are counted rather than sampled late
  always @(posedge clk_i) begin
    if (cal_start_o === 1'b1) n_cal <= n_cal + 8'h01;
    if (sync_release_o === 1'b1) n_rel <= n_rel + 8'h01;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done;
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  // ack is registered, so right after the edge it still shows the sample
  task automatic wb(logic w, logic [7:0] idx, logic [7:0] d, logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {2'b00, idx, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      test_done();
    end
    rd = wb_dat_o[7:0];
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    wb(1'b1, idx, d, 4'h1);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rchk(logic [7:0] idx, logic [7:0] exp);
    wb(1'b0, idx, 8'h00, 4'hf);
    chk("read", {24'h0, exp}, {24'h0, rd});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rchk(IDX_PUMP_CURRENT, 8'h00);
    rchk(IDX_FB_COUNTS, 8'h00);
    rchk(IDX_LOOP_CTRL, 8'h03); // reset
    rchk(IDX_OSC_CTRL, 8'h00); // reset
    chk("ab", 32'h2, 32'(phase_freq_detector_ab_o)); // auto high
    chk("cp", 32'h3, 32'(cp_mode_o)); // normal
    chk("hold", 32'h1, 32'(sync_hold_o)); // held
    chk("calrst", 32'h1, 32'(cal_reset_o)); // idle
  endtask
  task automatic t_counts;
    wr(IDX_PUMP_CURRENT, 8'hff);
    chk("pump", 32'hff, 32'(pump_current_o)); // full scale
    wr(IDX_FB_COUNTS, 8'hc7); // main 7 allows any remainder
    chk("main", 32'h07, 32'(fb_main_count_o)); // low six
    chk("rem", 32'h3, 32'(fb_rem_count_o)); // top two
    chk("ratio", 32'h1f, 32'(fb_ratio_o)); // 4b plus a
    wb(1'b1, IDX_FB_COUNTS, 8'h44, 4'h0);
    rchk(IDX_FB_COUNTS, 8'hc7); // unselected lane
    wr(IDX_FB_COUNTS, 8'h3f); // remainder 0 is always legal
    chk("ratio", 32'hfc, 32'(fb_ratio_o)); // largest main
  endtask
  task automatic t_loop;
    wr(IDX_LOOP_CTRL, 8'hbf); // reserved bit 6 kept zero
    rchk(IDX_LOOP_CTRL, 8'hb3); // width cleared
    chk("pd", 32'h1, 32'(lockdet_pd_o)); // power down
    chk("dbl", 32'h1, 32'(ref_doubler_o)); // doubler
    chk("ab", 32'h0, 32'(phase_freq_detector_ab_o)); // minimum
    for (int i = 0; i < 4; i++) begin
      wr(IDX_LOOP_CTRL, 8'h10 | 8'(i * 5));
      chk("ab", 32'(i), 32'(phase_freq_detector_ab_o)); // width
      chk("cp", 32'(i), 32'(cp_mode_o)); // mode
      chk("pd", 32'h0, 32'(lockdet_pd_o)); // active
    end
    wr(IDX_LOOP_CTRL, 8'h0c);
    chk("ab", 32'h2, 32'(phase_freq_detector_ab_o)); // auto high
  endtask
  task automatic t_sync;
    wr(IDX_LOOP_CTRL, 8'h83);
    loop_locked_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("hold", 32'h1, 32'(sync_hold_o)); // masked lock
    chk("rel", 32'h0, 32'(n_rel)); // no release
    wr(IDX_LOOP_CTRL, 8'h03);
    repeat (6) @(posedge clk_i);
    chk("hold", 32'h0, 32'(sync_hold_o)); // released
    chk("rel", 32'h1, 32'(n_rel)); // one pulse
    loop_locked_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("hold", 32'h1, 32'(sync_hold_o)); // lock lost
    wr(IDX_OSC_CTRL, 8'h10);
    repeat (6) @(posedge clk_i);
    chk("hold", 32'h0, 32'(sync_hold_o)); // override
    chk("rel", 32'h2, 32'(n_rel)); // pulse
  endtask
  task automatic t_osc;
    wr(IDX_OSC_CTRL, 8'hf7); // reserved bit 3 kept zero
    rchk(IDX_OSC_CTRL, 8'h16); // stays set
    chk("mid", 32'h1, 32'(vco_midscale_o)); // midscale
    chk("cal", 32'h1, 32'(n_cal)); // start
    chk("calrst", 32'h0, 32'(cal_reset_o)); // running
    wr(IDX_OSC_CTRL, 8'h16);
    chk("cal", 32'h1, 32'(n_cal)); // no new edge
    wr(IDX_OSC_CTRL, 8'h00);
    chk("calrst", 32'h1, 32'(cal_reset_o)); // reset
    chk("mid", 32'h0, 32'(vco_midscale_o)); // normal
    wr(IDX_OSC_CTRL, 8'h02);
    chk("cal", 32'h2, 32'(n_cal)); // restart
  endtask
  task automatic t_unmapped;
    wb(1'b1, 8'h10, 8'h5a, 4'h1);
    chk("err", 32'h1, 32'(er));
    rchk(IDX_PUMP_CURRENT, 8'hff);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_counts();
    t_loop();
    t_sync();
    t_osc();
    t_unmapped();
    test_done();
  end
  // whole run needs well under two thousand cycles
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule
